// *** logic/can_xcvr_map.svh ***
`ifndef CAN_XCVR_MAP_SVH
`define CAN_XCVR_MAP_SVH
// Clock period in picoseconds (200 MHz)
`define CLK_PERIOD_PS 64'h0000_0000_0000_1388
// Minimum dominant timeout in microseconds
`define DOM_TIMEOUT_MIN_US 64'h0000_0000_0000_0578
// Maximum dominant timeout in microseconds
`define DOM_TIMEOUT_MAX_US 64'h0000_0000_0000_12C0
// Timeout in cycles, least time rounded up
`define DOM_TIMEOUT_CYCLES ((`DOM_TIMEOUT_MIN_US * 64'h0000_0000_000F_4240 + `CLK_PERIOD_PS - 64'h0000_0000_0000_0001) / `CLK_PERIOD_PS)
// Consecutive dominant bits allowed by the protocol
`define MAX_DOM_BITS 4'hB
// Counter width
`define DOM_CNT_W 32
`endif

// *** logic/can_xcvr_pkg.sv ***
package can_xcvr_pkg;
	typedef enum logic [2:0] {
		ST_RECESSIVE = 3'h1,
		ST_DOMINANT = 3'h2,
		ST_TIMED_OUT = 3'h4
	} tx_state_t;
	typedef logic [31:0] dom_cnt_t;
endpackage : can_xcvr_pkg

// *** logic/sync2.sv ***
`timescale 1ns/100ps
module sync2 #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	input wire logic i_async,
	output logic o_sync
);
	logic meta_ff;
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			meta_ff <= RESET_VAL;
			o_sync <= RESET_VAL;
		end else if (i_ce) begin
			meta_ff <= i_async;
			o_sync <= meta_ff;
		end
	end
endmodule : sync2

// *** logic/can_transceiver_logic_side.sv ***
`timescale 1ns/100ps
`include "can_xcvr_map.svh"
module can_transceiver_logic_side #(
	parameter logic [31:0] DOM_TIMEOUT_CYC = 32'(`DOM_TIMEOUT_CYCLES)
) (
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	input wire logic i_txd,
	input wire logic i_polarity_select,
	input wire logic i_canh,
	input wire logic i_canl,
	output logic o_rxd,
	output logic o_canh,
	output logic o_canh_oe,
	output logic o_canl,
	output logic o_canl_oe
);
	// Transmit idles high so reset leaves no false rising edge
	localparam logic [3:0] SYNC_RESET = 4'h1;
	logic [3:0] pin_async;
	logic [3:0] pin_sync;
	logic txd_s;
	logic polarity_s;
	logic canh_s;
	logic canl_s;
	logic txd_prev_ff;
	can_xcvr_pkg::tx_state_t state_ff;
	can_xcvr_pkg::tx_state_t nxt_state;
	can_xcvr_pkg::dom_cnt_t cnt_ff;

	assign pin_async = {i_canl, i_canh, i_polarity_select, i_txd};

	// Every pin crosses in from outside the clock domain
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin_sync
			sync2 #(
				.RESET_VAL(SYNC_RESET[gi])
			) sync2_inst (
				.i_sys_clk(i_sys_clk),
				.i_reset(i_reset),
				.i_ce(i_ce),
				.i_async(pin_async[gi]),
				.o_sync(pin_sync[gi])
			);
		end
	endgenerate

	assign txd_s = pin_sync[0];
	assign polarity_s = pin_sync[1];
	assign canh_s = pin_sync[2];
	assign canl_s = pin_sync[3];

	// Bus reads dominant when the lines show the active pair for this polarity
	function automatic logic bus_dominant(input logic h, input logic l, input logic swap);
		bus_dominant = swap ? (!h && l) : (h && !l);
	endfunction : bus_dominant

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			txd_prev_ff <= 1'b1;
		end else if (i_ce) begin
			txd_prev_ff <= txd_s;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			can_xcvr_pkg::ST_RECESSIVE: begin
				if (!txd_s)
					nxt_state = can_xcvr_pkg::ST_DOMINANT;
			end
			can_xcvr_pkg::ST_DOMINANT: begin
				if (txd_s)
					nxt_state = can_xcvr_pkg::ST_RECESSIVE;
				else if (cnt_ff >= DOM_TIMEOUT_CYC)
					nxt_state = can_xcvr_pkg::ST_TIMED_OUT;
			end
			can_xcvr_pkg::ST_TIMED_OUT: begin
				// Held recessive until the controller lets go
				if (txd_s && !txd_prev_ff)
					nxt_state = can_xcvr_pkg::ST_RECESSIVE;
			end
			default: nxt_state = can_xcvr_pkg::ST_RECESSIVE;
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			state_ff <= can_xcvr_pkg::ST_RECESSIVE;
		end else if (i_ce) begin
			state_ff <= nxt_state;
		end
	end

	// Saturates so a stuck-low input never wraps back into dominant
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			cnt_ff <= '0;
		end else if (i_ce) begin
			if (txd_s)
				cnt_ff <= '0;
			else if (cnt_ff < DOM_TIMEOUT_CYC)
				cnt_ff <= cnt_ff + 32'h0000_0001;
		end
	end

	// Enables follow the next state so they stay in step with state_ff
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_canh_oe <= 1'b0;
			o_canl_oe <= 1'b0;
		end else if (i_ce) begin
			o_canh_oe <= (nxt_state == can_xcvr_pkg::ST_DOMINANT);
			o_canl_oe <= (nxt_state == can_xcvr_pkg::ST_DOMINANT);
		end
	end

	// Levels stand constantly; only the enables mark a dominant bit
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_canh <= 1'b0;
			o_canl <= 1'b0;
		end else if (i_ce) begin
			o_canh <= !polarity_s;
			o_canl <= polarity_s;
		end
	end

	// Assertion helper: length of the drive now in progress
	can_xcvr_pkg::dom_cnt_t drive_run_ff;
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			drive_run_ff <= '0;
		end else if (i_ce) begin
			if (!o_canh_oe)
				drive_run_ff <= '0;
			else if (drive_run_ff < DOM_TIMEOUT_CYC)
				drive_run_ff <= drive_run_ff + 32'h0000_0001;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			o_rxd <= 1'b1;
		end else if (i_ce) begin
			o_rxd <= !bus_dominant(canh_s, canl_s, polarity_s);
		end
	end

	sequence s_held_low;
		(i_ce && !txd_s) [*8];
	endsequence

	sequence s_txd_rise;
		(i_ce && !txd_s) ##1 (i_ce && txd_s);
	endsequence

	sequence s_limit_reached;
		i_ce && state_ff == can_xcvr_pkg::ST_DOMINANT && !txd_s
			&& cnt_ff >= DOM_TIMEOUT_CYC;
	endsequence

	a_drive_when_low: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(state_ff == can_xcvr_pkg::ST_DOMINANT) |-> (o_canh_oe && o_canl_oe))
		else $error("bus not driven while dominant");
	a_release_high: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(i_ce && txd_s) |=> (!i_ce || (!o_canh_oe && !o_canl_oe)))
		else $error("bus driven while transmit high");
	a_rxd_recessive: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(i_ce && canh_s == canl_s) |=> (!i_ce || o_rxd))
		else $error("rxd low on recessive bus");
	a_normal_polarity: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(i_ce && !polarity_s) |=> (!i_ce || (o_canh && !o_canl)))
		else $error("normal polarity levels wrong");
	a_swapped_polarity: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(i_ce && polarity_s) |=> (!i_ce || (!o_canh && o_canl)))
		else $error("swapped polarity levels wrong");
	a_timeout_release: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(i_ce && state_ff == can_xcvr_pkg::ST_TIMED_OUT) |-> !o_canh_oe)
		else $error("bus driven after timeout");
	a_timeout_hold: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(i_ce && state_ff == can_xcvr_pkg::ST_TIMED_OUT && !(txd_s && !txd_prev_ff))
		|=> (!i_ce || state_ff == can_xcvr_pkg::ST_TIMED_OUT))
		else $error("timeout left without rising edge");
	a_count_restart: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(i_ce && txd_s) |=> (!i_ce || cnt_ff == '0))
		else $error("timeout count not restarted");
	a_count_grows: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(s_held_low ##0 (cnt_ff < DOM_TIMEOUT_CYC)) |-> cnt_ff >= 32'h0000_0007)
		else $error("timeout count not advancing");
	a_timeout_entry: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		s_limit_reached |=> (state_ff == can_xcvr_pkg::ST_TIMED_OUT && !o_canh_oe))
		else $error("limit reached but bus still driven");
	a_drive_bound: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		o_canh_oe |-> (drive_run_ff < DOM_TIMEOUT_CYC))
		else $error("dominant drive outlasted the timeout");
	a_count_bound: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		cnt_ff <= DOM_TIMEOUT_CYC)
		else $error("timeout count past its limit");
	a_resume_edge: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(s_txd_rise ##0 (state_ff == can_xcvr_pkg::ST_TIMED_OUT))
		|=> (state_ff == can_xcvr_pkg::ST_RECESSIVE))
		else $error("rising edge did not end the timeout");
	a_enter_dominant: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(i_ce && !txd_s && state_ff == can_xcvr_pkg::ST_RECESSIVE)
		|=> (o_canh_oe && o_canl_oe))
		else $error("low transmit did not start a drive");
	a_oe_pair: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		o_canh_oe == o_canl_oe)
		else $error("line enables disagree");
	a_rxd_dominant: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(i_ce && !polarity_s && canh_s && !canl_s) |=> !o_rxd)
		else $error("rxd high on dominant bus");
	a_rxd_swapped: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(i_ce && polarity_s && !canh_s && canl_s) |=> !o_rxd)
		else $error("rxd high on swapped dominant bus");
	a_state_legal: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		$onehot(state_ff))
		else $error("transmit state not one-hot");
	a_freeze_state: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		!i_ce |=> ($stable(state_ff) && $stable(cnt_ff)))
		else $error("state moved while clock enable low");
	a_freeze_outputs: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		!i_ce |=> ($stable(o_canh_oe) && $stable(o_rxd)))
		else $error("outputs moved while clock enable low");
endmodule : can_transceiver_logic_side

// *** tb/can_bus_model.sv ***
`timescale 1ns/100ps
module can_bus_model (
	input wire logic i_canh,
	input wire logic i_canh_oe,
	input wire logic i_canl,
	input wire logic i_canl_oe,
	input wire logic i_ext_dom,
	input wire logic i_polarity_select,
	output logic o_canh,
	output logic o_canl
);
	// Released lines sit level unless i_ext_dom drives the active line; level reads as recessive
	assign o_canh = i_canh_oe ? i_canh : (i_ext_dom & !i_polarity_select);
	assign o_canl = i_canl_oe ? i_canl : (i_ext_dom & i_polarity_select);
endmodule : can_bus_model

// *** tb/can_transceiver_logic_side_bench.sv ***
`timescale 1ns/100ps
module can_transceiver_logic_side_bench;
	logic clk = 0, rst = 1, ce = 1, txd = 1, polarity = 0, ext = 0;
	logic canh_s, canl_s, rxd, canh, canl, hoe, loe;
	int bad_count = 0, comparisons = 0;
	initial forever #2.5 clk = ~clk;
	can_transceiver_logic_side #(.DOM_TIMEOUT_CYC(32'h0000_0014)) can_transceiver_logic_side_inst (
		.i_sys_clk(clk), .i_reset(rst), .i_ce(ce), .i_txd(txd), .i_polarity_select(polarity),
		.i_canh(canh_s), .i_canl(canl_s), .o_rxd(rxd), .o_canh(canh), .o_canh_oe(hoe),
		.o_canl(canl), .o_canl_oe(loe));
	can_bus_model can_bus_model_inst (.i_canh(canh), .i_canh_oe(hoe), .i_canl(canl),
		.i_canl_oe(loe), .i_ext_dom(ext), .i_polarity_select(polarity), .o_canh(canh_s),
		.o_canl(canl_s));
	task automatic chk(input string what, input logic seen, input logic exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %b seen %b", what, exp, seen);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic drv(input logic v, input int n);
		@(posedge clk) txd <= v;
		tick(n);
	endtask : drv
	// Loop back to rxd takes three edges out and three edges in
	task automatic t_polarity(input logic p);
		@(posedge clk) polarity <= p;
		drv(1'h0, 8);
		chk("oe_h", hoe, 1'h1);
		chk("oe_l", loe, 1'h1);
		chk("canh", canh, !p);
		chk("canl", canl, p);
		chk("rxd dom", rxd, 1'h0);
		drv(1'h1, 8);
		chk("oe rel", hoe, 1'h0);
		chk("oe_l rel", loe, 1'h0);
		chk("rxd rec", rxd, 1'h1);
		@(posedge clk) ext <= 1'h1;
		tick(4);
		chk("rxd other", rxd, 1'h0);
		@(posedge clk) ext <= 1'h0;
		tick(4);
		chk("rxd back", rxd, 1'h1);
	endtask : t_polarity
	// Two sync edges and the output flop, then exactly the limit of drive
	task automatic t_timeout;
		drv(1'h0, 22);
		chk("oe early", hoe, 1'h1);
		chk("rxd held", rxd, 1'h0);
		tick(1);
		chk("oe timeout", hoe, 1'h0);
		tick(4);
		chk("rxd free", rxd, 1'h1);
		tick(10);
		chk("stays off", hoe, 1'h0);
		drv(1'h1, 4);
		drv(1'h0, 4);
		chk("resumed", hoe, 1'h1);
		drv(1'h1, 4);
	endtask : t_timeout
	// Two short lows together exceed the limit; only a stale count trips
	task automatic t_restart;
		drv(1'h0, 15);
		drv(1'h1, 3);
		drv(1'h0, 15);
		chk("restart", hoe, 1'h1);
		drv(1'h1, 4);
	endtask : t_restart
	// Frozen cycles must not count toward the limit
	task automatic t_freeze;
		drv(1'h0, 6);
		chk("oe before freeze", hoe, 1'h1);
		@(posedge clk) ce <= 1'h0;
		tick(40);
		chk("oe frozen", hoe, 1'h1);
		chk("rxd frozen", rxd, 1'h0);
		@(posedge clk) ce <= 1'h1;
		tick(10);
		chk("oe after freeze", hoe, 1'h1);
		drv(1'h1, 6);
		chk("oe freeze rel", hoe, 1'h0);
	endtask : t_freeze
	task automatic test_done;
		$display("Checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		tick(2);
		chk("reset rxd", rxd, 1'h1);
		chk("reset oe", hoe, 1'h0);
		chk("reset canh", canh, 1'h1);
		t_polarity(1'h0);
		t_polarity(1'h1);
		t_timeout();
		t_restart();
		t_freeze();
		test_done();
	end
endmodule : can_transceiver_logic_side_bench
